// >>> src/tbtc_pkg.sv
package tbtc_pkg;

  // ----------------------------------------
  // register map (index, byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0]  PHY_MAIN_CONTROL_IDX               = 8'h19;
  localparam logic [7:0]  TEN_BASE_T_STATUS_CONTROL_IDX      = 8'h1A;
  localparam logic [7:0]  CODER_TEST_SELFTEST_EXTENSIONS_IDX = 8'h1B;
  localparam logic [7:0]  PHY_STATUS_SUMMARY_IDX             = 8'h1E;
  localparam int          ADDR_W                             = 12;
  localparam logic [31:0] READ_ZERO                          = 32'h0000_0000;

  // ----------------------------------------
  // ten_base_t_status_control fields
  // ----------------------------------------
  localparam int          SQUELCH_LSB    = 9;
  localparam int          SQUELCH_W      = 3;
  localparam int          ECHO_DIS_BIT   = 8;
  localparam int          NLP_DIS_BIT    = 7;
  localparam int          FORCE_LINK_BIT = 6;
  localparam int          POLARITY_BIT   = 4;
  localparam int          SQE_DIS_BIT    = 1;
  localparam int          JABBER_GUARD_DISABLE_BIT = 0;
  localparam logic [15:0] TBT_RESET      = 16'h0804;
  localparam logic [15:0] TBT_WR_MASK    = 16'hFFEF;

  // ----------------------------------------
  // coder_test_selftest_extensions fields
  // ----------------------------------------
  localparam int          TALLY_LSB    = 8;
  localparam int          TALLY_W      = 8;
  localparam int          CONT_BIT     = 5;
  localparam int          PATT_EN_BIT  = 4;
  localparam int          GAP_BIT      = 2;
  localparam int          PATT_SEL_LSB = 0;
  localparam logic [15:0] EXT_RESET    = 16'h0000;
  localparam logic [15:0] EXT_WR_MASK  = 16'h00FF;

  // ----------------------------------------
  // phy_main_control / phy_status_summary fields
  // ----------------------------------------
  localparam int LAUNCH_BIT          = 8;
  localparam int POLARITY_MIRROR_BIT = 12;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_MHZ       = 250;
  localparam int          GAP_LONG_US   = 15;
  localparam int          GAP_SHORT_US  = 10;
  localparam int          GAP_W         = 12;
  localparam logic [11:0] GAP_LONG_CYC  = 12'(GAP_LONG_US * CLK_MHZ);
  localparam logic [11:0] GAP_SHORT_CYC = 12'(GAP_SHORT_US * CLK_MHZ);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PAT_DATA_EOP0       = 2'b00,
    PAT_DATA_EOP1       = 2'b01,
    PAT_LINK_PULSES     = 2'b10,
    PAT_MANCHESTER_ONES = 2'b11
  } tbtc_pattern_t;

  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ACCESS = 1'b1
  } tbtc_bus_state_t;

  typedef struct packed {
    logic [2:0] squelch;
    logic       rxEcho;
    logic       nlpTxEnable;
    logic       linkGood10;
    logic       sqeEnable;
    logic       jabberEnable;
  } tbtc_line_ctrl_t;

  typedef struct packed {
    logic          run;
    logic          continuous;
    logic          patternEnable;
    tbtc_pattern_t patternSelect;
    logic [11:0]   gapCycles;
  } tbtc_test_ctrl_t;

  function automatic logic [11:0] regAddr(input logic [7:0] idx);
    regAddr = {2'b00, idx, 2'b00};
  endfunction

endpackage

// >>> src/tbtc_polarity_latch.sv
`timescale 1ns/1ps
module tbtc_polarity_latch (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // events
  input  wire logic polaritySet,
  input  wire logic polarityClear,
  // state
  output logic      polarityFlag
);
  import tbtc_pkg::*;

  logic flag_r;
  logic flag_nxt;

  // a detection in the clearing cycle survives: set wins
  always_comb begin
    flag_nxt = flag_r;
    if (polarityClear) begin
      flag_nxt = 1'b0;
    end
    if (polaritySet) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign polarityFlag = flag_r;
endmodule

// >>> src/tbtc_error_tally.sv
`timescale 1ns/1ps
module tbtc_error_tally #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // control
  input  wire logic             restart,
  input  wire logic             running,
  input  wire logic             nibbleError,
  // count
  output logic [WIDTH-1:0]      tally
);
  import tbtc_pkg::*;

  localparam logic [WIDTH-1:0] TALLY_MAX = {WIDTH{1'b1}};

  logic [WIDTH-1:0] tally_r;
  logic [WIDTH-1:0] tally_nxt;

  always_comb begin
    tally_nxt = tally_r;
    if (restart) begin
      tally_nxt = '0;
    end else if (running && nibbleError && tally_r != TALLY_MAX) begin
      tally_nxt = tally_r + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tally_r <= '0;
    end else begin
      tally_r <= tally_nxt;
    end
  end

  assign tally = tally_r;
endmodule

// >>> src/tbtc_ctrl_regs.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Operation
// - squelch threshold field at bits 11:9, resets to 100
// - half-duplex 10 Mb echoes transmit onto receive unless echo disable bit 8 set
// - echo disable leaves the basic mode control loopback untouched
// - bit 7 set stops normal link pulse transmission
// - bit 6 set forces a good 10 Mb link indication
// - bit 4 read-only latched-high polarity flag, mirrored in status summary bit 12
// - reading the 10BASE-T register clears the flag; status summary read does not
// - bit 1 disables heartbeat only in half-duplex 10 Mb
// - at 100 Mb or full duplex heartbeat is off regardless
// - bit 0 disables jabber protection, only in 10BASE-T
// - read-only eight-bit errored nibble counter at bits 15:8
// - counter returns to zero when self-test restarts
// - counter saturates at full count
// - bit 5 gives gapless pseudo-random self-test transmission
// - continuous mode works with the self-test launch control
// - extension bit 4 enables the 10 Mb coder test pattern
// - two-bit select picks EOP0, EOP1, link pulses or Manchester ones
// - gap select gives 15 or 10 microsecond spacing
// - self-test runs while launch bit 8 is one
module tbtc_ctrl_regs
  import tbtc_pkg::*;
#(
  parameter int TALLY_W_P = tbtc_pkg::TALLY_W
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tbtc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // line status from the transceiver
  input  wire logic                      speed100,
  input  wire logic                      fullDuplex,
  input  wire logic                      basicLoopback,
  input  wire logic                      linkDetected10,
  input  wire logic                      polarityInverted,
  input  wire logic                      nibbleError,
  // controls to the transceiver
  output tbtc_pkg::tbtc_line_ctrl_t      lineCtrl,
  output tbtc_pkg::tbtc_test_ctrl_t      testCtrl
);
  import tbtc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  tbtc_bus_state_t        busState_r;
  tbtc_bus_state_t        busState_nxt;
  logic                   pready_r;
  logic                   pready_nxt;
  logic [31:0]            prdata_r;
  logic [31:0]            prdata_nxt;
  logic                   pslverr_r;
  logic                   pslverr_nxt;
  logic                   snapPolarity_r;
  logic                   snapPolarity_nxt;
  logic [15:0]            tbt_r;
  logic [15:0]            tbt_nxt;
  logic [15:0]            ext_r;
  logic [15:0]            ext_nxt;
  logic                   launch_r;
  logic                   launch_nxt;
  tbtc_line_ctrl_t        lineCtrl_r;
  tbtc_line_ctrl_t        lineCtrl_nxt;
  tbtc_test_ctrl_t        testCtrl_r;
  tbtc_test_ctrl_t        testCtrl_nxt;

  logic                   polarityFlag;
  logic [TALLY_W_P-1:0]   tally;
  logic                   setupCycle;
  logic                   commit;
  logic                   wrCommit;
  logic                   rdTbtCommit;
  logic                   restart;
  logic                   halfDup10;
  logic [15:0]            laneMask;
  logic                   selMain;
  logic                   selTbt;
  logic                   selExt;
  logic                   selSts;
  logic [SQUELCH_W-1:0]   squelchField;
  logic                   echoDisable;
  logic                   nlpDisable;
  logic                   forceLink;
  logic                   sqeDisable;
  logic                   jabberDisable;
  logic                   contMode;
  logic                   patternOn;
  logic                   gapLong;
  tbtc_pattern_t          patternCode;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == regAddr(idx));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, PHY_MAIN_CONTROL_IDX) || hit(a, TEN_BASE_T_STATUS_CONTROL_IDX) ||
             hit(a, CODER_TEST_SELFTEST_EXTENSIONS_IDX) || hit(a, PHY_STATUS_SUMMARY_IDX);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wr, input logic [15:0] mask);
    merge = (old & ~mask) | (wr & mask);
  endfunction

  // one decode per register, shared by the read and write paths
  assign selMain = hit(paddr, PHY_MAIN_CONTROL_IDX);
  assign selTbt  = hit(paddr, TEN_BASE_T_STATUS_CONTROL_IDX);
  assign selExt  = hit(paddr, CODER_TEST_SELFTEST_EXTENSIONS_IDX);
  assign selSts  = hit(paddr, PHY_STATUS_SUMMARY_IDX);

  assign setupCycle  = psel && !penable;
  assign commit      = psel && penable && pready_r && busState_r == BUS_ACCESS;
  assign wrCommit    = commit && pwrite && !pslverr_r;
  // clear only what the read returned, so a later detection is not lost
  assign rdTbtCommit = commit && !pwrite && selTbt && snapPolarity_r;
  assign laneMask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // ----------------------------------------
  // apb bus phase
  // ----------------------------------------
  always_comb begin
    busState_nxt     = busState_r;
    pready_nxt       = 1'b0;
    prdata_nxt       = prdata_r;
    pslverr_nxt      = 1'b0;
    snapPolarity_nxt = snapPolarity_r;
    case (busState_r)
      BUS_IDLE: begin
        if (setupCycle) begin
          busState_nxt     = BUS_ACCESS;
          pready_nxt       = 1'b1;
          pslverr_nxt      = !mapped(paddr);
          snapPolarity_nxt = polarityFlag;
          prdata_nxt       = READ_ZERO;
          if (!pwrite) begin
            if (selMain) begin
              prdata_nxt[LAUNCH_BIT] = launch_r;
            end else if (selTbt) begin
              prdata_nxt[15:0]         = tbt_r;
              prdata_nxt[POLARITY_BIT] = polarityFlag;
            end else if (selExt) begin
              prdata_nxt[15:0]                       = ext_r;
              prdata_nxt[TALLY_LSB +: TALLY_W_P]     = tally;
            end else if (selSts) begin
              prdata_nxt[POLARITY_MIRROR_BIT] = polarityFlag;
            end
          end
        end
      end
      BUS_ACCESS: begin
        pslverr_nxt = pslverr_r;
        if (commit) begin
          busState_nxt = BUS_IDLE;
          pslverr_nxt  = 1'b0;
        end else begin
          pready_nxt = pready_r;
        end
      end
      default: begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busState_r     <= BUS_IDLE;
      pready_r       <= 1'b0;
      prdata_r       <= READ_ZERO;
      pslverr_r      <= 1'b0;
      snapPolarity_r <= 1'b0;
    end else begin
      busState_r     <= busState_nxt;
      pready_r       <= pready_nxt;
      prdata_r       <= prdata_nxt;
      pslverr_r      <= pslverr_nxt;
      snapPolarity_r <= snapPolarity_nxt;
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // reserved bits are stored as written; software keeps them at their values
  always_comb begin
    tbt_nxt    = tbt_r;
    ext_nxt    = ext_r;
    launch_nxt = launch_r;
    if (wrCommit) begin
      if (selTbt) begin
        tbt_nxt = merge(tbt_r, pwdata[15:0], TBT_WR_MASK & laneMask);
      end else if (selExt) begin
        ext_nxt = merge(ext_r, pwdata[15:0], EXT_WR_MASK & laneMask);
      end else if (selMain && pstrb[1]) begin
        launch_nxt = pwdata[LAUNCH_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tbt_r    <= TBT_RESET;
      ext_r    <= EXT_RESET;
      launch_r <= 1'b0;
    end else begin
      tbt_r    <= tbt_nxt;
      ext_r    <= ext_nxt;
      launch_r <= launch_nxt;
    end
  end

  // a launch written while stopped (stopped-to-running) restarts the tally; rewriting it while running does not
  assign restart = launch_nxt && !launch_r;

  // ----------------------------------------
  // field views
  // ----------------------------------------
  // named views keep every bit position in one place
  assign squelchField  = tbt_r[SQUELCH_LSB +: SQUELCH_W];
  assign echoDisable   = tbt_r[ECHO_DIS_BIT];
  assign nlpDisable    = tbt_r[NLP_DIS_BIT];
  assign forceLink     = tbt_r[FORCE_LINK_BIT];
  assign sqeDisable    = tbt_r[SQE_DIS_BIT];
  assign jabberDisable = tbt_r[JABBER_GUARD_DISABLE_BIT];
  assign contMode      = ext_r[CONT_BIT];
  assign patternOn     = ext_r[PATT_EN_BIT];
  // select and gap reach the coder even while the pattern is off; the coder gates them
  assign gapLong       = ext_r[GAP_BIT];
  assign patternCode   = tbtc_pattern_t'(ext_r[PATT_SEL_LSB +: $bits(tbtc_pattern_t)]);

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  tbtc_polarity_latch u_polarity (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .polaritySet   (polarityInverted),
    .polarityClear (rdTbtCommit),
    .polarityFlag  (polarityFlag)
  );

  tbtc_error_tally #(
    .WIDTH (TALLY_W_P)
  ) u_tally (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .restart     (restart),
    .running     (launch_r),
    .nibbleError (nibbleError),
    .tally       (tally)
  );

  // ----------------------------------------
  // line and test controls
  // ----------------------------------------
  assign halfDup10 = !speed100 && !fullDuplex;

  always_comb begin
    lineCtrl_nxt.squelch      = squelchField;
    // basic loopback passes through whatever the echo disable says
    lineCtrl_nxt.rxEcho       = basicLoopback || (halfDup10 && !echoDisable);
    lineCtrl_nxt.nlpTxEnable  = !nlpDisable;
    lineCtrl_nxt.linkGood10   = forceLink || linkDetected10;
    lineCtrl_nxt.sqeEnable    = halfDup10 && !sqeDisable;
    // jabber guard is never forced here; continuous self-test relies on software
    lineCtrl_nxt.jabberEnable = !speed100 && !jabberDisable;
    testCtrl_nxt.run           = launch_r;
    testCtrl_nxt.continuous    = launch_r && contMode;
    testCtrl_nxt.patternEnable = patternOn;
    testCtrl_nxt.patternSelect = patternCode;
    testCtrl_nxt.gapCycles     = gapLong ? GAP_LONG_CYC : GAP_SHORT_CYC;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lineCtrl_r <= '0;
      testCtrl_r <= '0;
    end else begin
      lineCtrl_r <= lineCtrl_nxt;
      testCtrl_r <= testCtrl_nxt;
    end
  end

  assign pready   = pready_r;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  assign lineCtrl = lineCtrl_r;
  assign testCtrl = testCtrl_r;
endmodule

// >>> tb/tbtc_ctrl_regs_sva.sv
`timescale 1ns/1ps
module tbtc_ctrl_regs_sva
  import tbtc_pkg::*;
#(
  parameter int TALLY_W_P = 8
) (
  // clock and reset
  input wire logic                          sys_clk,
  input wire logic                          reset_n,
  // apb
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [tbtc_pkg::ADDR_W-1:0]   paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [3:0]                    pstrb,
  input wire logic                          pready,
  input wire logic [31:0]                   prdata,
  input wire logic                          pslverr,
  // line side
  input wire logic                          speed100,
  input wire logic                          fullDuplex,
  input wire logic                          basicLoopback,
  input wire logic                          linkDetected10,
  input wire tbtc_pkg::tbtc_line_ctrl_t     lineCtrl,
  input wire tbtc_pkg::tbtc_test_ctrl_t     testCtrl
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic setupCyc;
  logic mapped;
  logic tbtWrite;
  assign setupCyc = psel && !penable;
  assign mapped   = paddr inside {12'h064, 12'h068, 12'h06C, 12'h078};
  assign tbtWrite = psel && penable && pready && pwrite && paddr == 12'h068 && pstrb[1:0] == 2'b11;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  bus_answer_a: assert property (setupCyc |=> pready && prdata[31:16] == 16'h0000)
    else $error("no answer one cycle after setup");
  bus_single_a: assert property (pready |=> !pready) else $error("pready held too long");
  unmapped_err_a: assert property (setupCyc && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setupCyc && mapped |=> !pslverr) else $error("mapped access refused");
  echo_loop_a: assert property (basicLoopback |=> lineCtrl.rxEcho) else $error("loopback echo lost");
  sqe_off_a: assert property (speed100 || fullDuplex |=> !lineCtrl.sqeEnable)
    else $error("heartbeat on outside half 10");
  jabber_fast_a: assert property (speed100 |=> !lineCtrl.jabberEnable) else $error("jabber at 100");
  link_detect_a: assert property (linkDetected10 |=> lineCtrl.linkGood10) else $error("link lost");
  cont_run_a: assert property (testCtrl.continuous |-> testCtrl.run) else $error("continuous idle");
  gap_value_a: assert property ($past(reset_n) |-> testCtrl.gapCycles inside {12'hEA6, 12'h9C4})
    else $error("bad gap");
  line_write_a: assert property (tbtWrite |=> ##1 lineCtrl.nlpTxEnable == !$past(pwdata[7], 2)
    && lineCtrl.squelch == $past(pwdata[11:9], 2)) else $error("line control not updated");
endmodule
bind tbtc_ctrl_regs tbtc_ctrl_regs_sva #(.TALLY_W_P(TALLY_W_P)) u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .speed100(speed100), .fullDuplex(fullDuplex),
  .basicLoopback(basicLoopback), .linkDetected10(linkDetected10), .lineCtrl(lineCtrl), .testCtrl(testCtrl));

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import tbtc_pkg::*;
  logic            sys_clk = 1'b0;
  logic            reset_n;
  logic            psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rdv;
  logic [3:0]      pstrb;
  logic            speed100, fullDuplex, basicLoopback, linkDetected10, polarityInverted, nibbleError;
  tbtc_line_ctrl_t lineCtrl;
  tbtc_test_ctrl_t testCtrl;
  int              n_errors = 0;
  int              total_checks = 0;

  always #2 sys_clk = ~sys_clk;

  tbtc_ctrl_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .speed100(speed100), .fullDuplex(fullDuplex), .basicLoopback(basicLoopback),
    .linkDetected10(linkDetected10), .polarityInverted(polarityInverted), .nibbleError(nibbleError),
    .lineCtrl(lineCtrl), .testCtrl(testCtrl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // master waits for pready itself; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    chk("pready", 32'(pready), 32'h1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, exp);
    chk("pslverr", 32'(rerr), 32'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(12'h068, 32'h0804, "line reg reset");
    rd(12'h06C, 32'h0000, "ext reg reset");
    rd(12'h064, 32'h0000, "launch reset");
    chk("squelch", 32'(lineCtrl.squelch), 32'h4);
    $display("test reset done");
  endtask

  task automatic t_line;
    logic [15:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 16'h0BC7 : 16'h0804;
      apb(1'b1, 12'h068, {16'h0, v});
      for (int i = 0; i < 16; i++) begin
        speed100 <= i[0];
        fullDuplex <= i[1];
        basicLoopback <= i[2];
        linkDetected10 <= i[3];
        tick(2);
        chk("lineCtrl", 32'(lineCtrl), {24'h0, v[11:9], i[2] | (!i[0] & !i[1] & !v[8]), !v[7], v[6] | i[3],
          !i[0] & !i[1] & !v[1], !i[0] & !v[0]});
      end
    end
    apb(1'b1, 12'h068, 32'h0FD7);
    rd(12'h068, 32'h0FC7, "polarity not writable");
    apb(1'b1, 12'h068, 32'h0804);
    $display("test line done");
  endtask

  task automatic t_pol;
    polarityInverted <= 1'b1;
    tick(1);
    polarityInverted <= 1'b0;
    tick(2);
    rd(12'h078, 32'h1000, "mirror set");
    rd(12'h078, 32'h1000, "mirror kept");
    rd(12'h068, 32'h0814, "flag set");
    rd(12'h068, 32'h0804, "flag cleared");
    rd(12'h078, 32'h0000, "mirror cleared");
    polarityInverted <= 1'b1;
    rd(12'h068, 32'h0814, "flag held");
    polarityInverted <= 1'b0;
    rd(12'h068, 32'h0814, "set wins");
    rd(12'h068, 32'h0804, "flag cleared again");
    $display("test polarity done");
  endtask

  task automatic t_self;
    {speed100, fullDuplex, basicLoopback, linkDetected10} <= 4'h0;
    apb(1'b1, 12'h068, 32'h0805);
    apb(1'b1, 12'h064, 32'h0100);
    chk("jabber guard off", 32'(lineCtrl.jabberEnable), 32'h0);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h06C, {26'h0, 2'b11, 1'b0, s[0], s[1:0]});
      tick(2);
      chk("testCtrl", 32'(testCtrl), {15'h0, 3'b111, s[1:0], s[0] ? 12'hEA6 : 12'h9C4});
    end
    nibbleError <= 1'b1;
    tick(3);
    nibbleError <= 1'b0;
    rd(12'h06C, 32'h0337, "tally three");
    apb(1'b1, 12'h06C, 32'hFF37);
    rd(12'h06C, 32'h0337, "tally not writable");
    nibbleError <= 1'b1;
    tick(260);
    nibbleError <= 1'b0;
    rd(12'h06C, 32'hFF37, "tally sticks");
    apb(1'b1, 12'h064, 32'h0000);
    tick(2);
    chk("stopped", 32'({testCtrl.run, testCtrl.continuous}), 32'h0);
    apb(1'b1, 12'h064, 32'h0100);
    rd(12'h06C, 32'h0037, "tally restart");
    apb(1'b1, 12'h068, 32'h0804);
    $display("test selftest done");
  endtask

  task automatic t_err;
    apb(1'b0, 12'h070, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    chk("unmapped data", rdv, 32'h0);
    apb(1'b1, 12'h0FC, 32'hFFFF);
    chk("unmapped wr err", 32'(rerr), 32'h1);
    rd(12'h068, 32'h0804, "line reg untouched");
    pstrb <= 4'h1;
    apb(1'b1, 12'h068, 32'h0F05);
    pstrb <= 4'h3;
    rd(12'h068, 32'h0805, "low lane only");
    apb(1'b1, 12'h068, 32'h0804);
    $display("test unmapped done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, speed100, fullDuplex, basicLoopback, linkDetected10} = '0;
    {polarityInverted, nibbleError} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h3;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_line();
    t_pol();
    t_self();
    t_err();
    summarize();
  end

  // whole run is under 500 cycles; this is thirty times that
  initial begin
    #60000;
    n_errors++;
    summarize();
  end
endmodule
